// ---- design/ddp_pkg.sv ----
// completion-pending interrupt bookkeeping: shared constants and carriers
// assumes a 32-bit apb slave and a single 20 mhz controller clock
package ddp_pkg;

    // register byte offsets on the apb window
    localparam logic [7:0] DDP_OFF_EN_MASK_LO = 8'h00;
    localparam logic [7:0] DDP_OFF_EN_MASK_HI = 8'h04;
    localparam logic [7:0] DDP_OFF_EN_CLR_LO = 8'h08;
    localparam logic [7:0] DDP_OFF_EN_CLR_HI = 8'h0c;
    localparam logic [7:0] DDP_OFF_EN_SET_LO = 8'h10;
    localparam logic [7:0] DDP_OFF_EN_SET_HI = 8'h14;
    localparam logic [7:0] DDP_OFF_PEND_LO = 8'h18;
    localparam logic [7:0] DDP_OFF_PEND_HI = 8'h1c;
    localparam logic [7:0] DDP_OFF_PEND_CLR_LO = 8'h20;
    localparam logic [7:0] DDP_OFF_PEND_CLR_HI = 8'h24;

    // widths and layout
    localparam int DDP_ADDR_W = 8;
    localparam int DDP_DATA_W = 32;
    localparam int DDP_CODE_W = 6;
    localparam int DDP_NUM_CODES = 64;
    localparam int DDP_HALF = 32;

    // reset values
    localparam logic [63:0] DDP_RST_MASK = 64'h0000000000000000;
    localparam logic [63:0] DDP_RST_PEND = 64'h0000000000000000;
    localparam logic [31:0] DDP_RST_DATA = 32'h00000000;

    // apb request as driven by the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [DDP_ADDR_W-1:0] paddr;
        logic [DDP_DATA_W-1:0] pwdata;
    } ddp_apb_req_s;

    // one completion report: channel options plus which kind of completion
    typedef struct packed {
        logic valid;
        logic final_hit;
        logic final_done_irq_en;
        logic interim_done_irq_en;
        logic [DDP_CODE_W-1:0] completion_code;
    } ddp_done_s;

    // whole state of the block
    typedef struct packed {
        logic [DDP_NUM_CODES-1:0] irq_enable_mask;
        logic [DDP_NUM_CODES-1:0] completion_pending;
        logic armed;
        logic irq;
        logic pready;
        logic pslverr;
        logic [DDP_DATA_W-1:0] prdata;
    } ddp_state_s;

endpackage

// ---- design/ddp_dma_done_irq_pending.sv ----
// completion-code pending bits, enable mask and one level interrupt
// assumes apb master and both completion sources run on ref_clk
//
// How it works
// - ones on low set port raise enables
// - ones on upper set port raise enables
// - code counts only when matching enable set
// - engine reports normal, controller reports early completion
// - code equals options completion-code field
// - code n sets pending bit n
// - pending stays set until software clears
// - ones on low clear port drop pending
// - ones on upper clear port drop pending
// - no new interrupt until all pending cleared
// - pending reads back, resets to zero
// - six-bit code selects one of 64
// - enable bit gates its code's interrupt
// - ones on enable clear ports drop enables
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module ddp_dma_done_irq_pending
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // apb slave
    input wire ddp_pkg::ddp_apb_req_s apb_req,
    output logic [ddp_pkg::DDP_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // completion reports
    input wire ddp_pkg::ddp_done_s engine_done,
    input wire ddp_pkg::ddp_done_s ctrl_early_done,
    // interrupt
    output logic done_irq
);
    import ddp_pkg::*;

    ddp_state_s st_q;
    ddp_state_s st_d;

    logic setup_phase;
    logic wr_fire;
    logic addr_hit;
    logic engine_take;
    logic early_take;
    logic [DDP_NUM_CODES-1:0] engine_onehot;
    logic [DDP_NUM_CODES-1:0] early_onehot;
    logic [DDP_NUM_CODES-1:0] set_vec;
    logic [DDP_NUM_CODES-1:0] pend_clr_vec;
    logic [DDP_NUM_CODES-1:0] en_set_vec;
    logic [DDP_NUM_CODES-1:0] en_clr_vec;
    logic [DDP_NUM_CODES-1:0] pend_next;
    logic [DDP_NUM_CODES-1:0] live_vec;
    logic [DDP_NUM_CODES-1:0] mask_next;
    logic [DDP_DATA_W-1:0] rd_mux;

    // a report counts only when the options allow the kind of completion seen
    always_comb
    begin
        engine_take = engine_done.valid &&
            (engine_done.final_hit ? engine_done.final_done_irq_en
                                   : engine_done.interim_done_irq_en);
        early_take = ctrl_early_done.valid &&
            (ctrl_early_done.final_hit ? ctrl_early_done.final_done_irq_en
                                       : ctrl_early_done.interim_done_irq_en);
    end

    // decode the six-bit code straight from the options field to one bit
    always_comb
    begin
        engine_onehot = '0;
        early_onehot = '0;
        engine_onehot[engine_done.completion_code] = engine_take;
        early_onehot[ctrl_early_done.completion_code] = early_take;
        set_vec = engine_onehot | early_onehot;
    end

    // apb phase decode; answer comes one cycle after setup, no wait states
    assign setup_phase = apb_req.psel && !apb_req.penable;
    assign wr_fire = apb_req.psel && apb_req.penable && apb_req.pwrite && st_q.pready;

    // write-one ports; zero bits leave their targets untouched
    always_comb
    begin
        en_set_vec = '0;
        en_clr_vec = '0;
        pend_clr_vec = '0;
        if (wr_fire)
        begin
            unique case (apb_req.paddr)
                DDP_OFF_EN_SET_LO: en_set_vec[DDP_HALF-1:0] = apb_req.pwdata;
                DDP_OFF_EN_SET_HI: en_set_vec[63:DDP_HALF] = apb_req.pwdata;
                DDP_OFF_EN_CLR_LO: en_clr_vec[DDP_HALF-1:0] = apb_req.pwdata;
                DDP_OFF_EN_CLR_HI: en_clr_vec[63:DDP_HALF] = apb_req.pwdata;
                DDP_OFF_PEND_CLR_LO: pend_clr_vec[DDP_HALF-1:0] = apb_req.pwdata;
                DDP_OFF_PEND_CLR_HI: pend_clr_vec[63:DDP_HALF] = apb_req.pwdata;
                default:
                begin
                    en_set_vec = '0;
                end
            endcase
        end
    end

    // read mux and address check; write-only ports read as zero
    always_comb
    begin
        rd_mux = DDP_RST_DATA;
        addr_hit = 1'b1;
        unique case (apb_req.paddr)
            DDP_OFF_EN_MASK_LO: rd_mux = st_q.irq_enable_mask[DDP_HALF-1:0];
            DDP_OFF_EN_MASK_HI: rd_mux = st_q.irq_enable_mask[63:DDP_HALF];
            DDP_OFF_PEND_LO: rd_mux = st_q.completion_pending[DDP_HALF-1:0];
            DDP_OFF_PEND_HI: rd_mux = st_q.completion_pending[63:DDP_HALF];
            DDP_OFF_EN_CLR_LO, DDP_OFF_EN_CLR_HI, DDP_OFF_EN_SET_LO, DDP_OFF_EN_SET_HI,
            DDP_OFF_PEND_CLR_LO, DDP_OFF_PEND_CLR_HI: rd_mux = DDP_RST_DATA;
            default: addr_hit = 1'b0;
        endcase
    end

    // a set in the same cycle as a clear wins, so no completion is lost
    assign pend_next = (st_q.completion_pending & ~pend_clr_vec) | set_vec;
    // set and clear of one enable bit together: the set is taken; kept apart
    // from the state copy so the interrupt term does not loop through st_d
    assign mask_next = (st_q.irq_enable_mask & ~en_clr_vec) | en_set_vec;
    assign live_vec = pend_next & mask_next;

    // next state of the whole block
    always_comb
    begin
        st_d = st_q;
        st_d.irq_enable_mask = mask_next;
        st_d.completion_pending = pend_next;
        // rearm only once every pending bit, enabled or not, is gone
        if (pend_next == '0)
        begin
            st_d.armed = 1'b1;
        end
        else if (st_q.armed && !st_q.irq && (live_vec != '0))
        begin
            st_d.armed = 1'b0;
        end
        // level stays up while any enabled bit pends; new rise needs the arm
        st_d.irq = (live_vec != '0) && (st_q.irq || st_q.armed);
        // apb answer registered in the setup cycle
        st_d.pready = setup_phase;
        st_d.pslverr = setup_phase && !addr_hit;
        if (setup_phase)
        begin
            st_d.prdata = apb_req.pwrite ? DDP_RST_DATA : rd_mux;
        end
    end

    // register the state
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            st_q.irq_enable_mask <= DDP_RST_MASK;
            st_q.completion_pending <= DDP_RST_PEND;
            st_q.armed <= 1'b1;
            st_q.irq <= 1'b0;
            st_q.pready <= 1'b0;
            st_q.pslverr <= 1'b0;
            st_q.prdata <= DDP_RST_DATA;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // outputs come straight from the state flops
    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign done_irq = st_q.irq;

    // ---- checks on the block's own behaviour ----
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    logic wr_en_set_lo;
    logic wr_en_set_hi;
    logic wr_en_clr_lo;
    logic wr_en_clr_hi;
    logic wr_pend_clr_lo;
    logic wr_pend_clr_hi;
    logic rd_pend_lo;
    logic rd_pend_hi;
    logic wr_pend_ro;
    assign wr_en_set_lo = wr_fire && (apb_req.paddr == DDP_OFF_EN_SET_LO);
    assign wr_en_set_hi = wr_fire && (apb_req.paddr == DDP_OFF_EN_SET_HI);
    assign wr_en_clr_lo = wr_fire && (apb_req.paddr == DDP_OFF_EN_CLR_LO);
    assign wr_pend_clr_lo = wr_fire && (apb_req.paddr == DDP_OFF_PEND_CLR_LO);
    assign wr_pend_clr_hi = wr_fire && (apb_req.paddr == DDP_OFF_PEND_CLR_HI);
    assign rd_pend_lo = setup_phase && !apb_req.pwrite && (apb_req.paddr == DDP_OFF_PEND_LO);
    assign rd_pend_hi = setup_phase && !apb_req.pwrite && (apb_req.paddr == DDP_OFF_PEND_HI);
    assign wr_en_clr_hi = wr_fire && (apb_req.paddr == DDP_OFF_EN_CLR_HI);
    assign wr_pend_ro = wr_fire &&
        ((apb_req.paddr == DDP_OFF_PEND_LO) || (apb_req.paddr == DDP_OFF_PEND_HI));

    property p_en_set_lo;
        wr_en_set_lo |=> (st_q.irq_enable_mask[31:0] ==
            ($past(st_q.irq_enable_mask[31:0]) | $past(apb_req.pwdata)));
    endproperty
    a_en_set_lo: assert property (p_en_set_lo)
        else $error("low enable set port did not set exactly the written ones");

    property p_en_set_hi;
        wr_en_set_hi |=> (st_q.irq_enable_mask[63:32] ==
            ($past(st_q.irq_enable_mask[63:32]) | $past(apb_req.pwdata)))
            && (st_q.irq_enable_mask[31:0] == $past(st_q.irq_enable_mask[31:0]));
    endproperty
    a_en_set_hi: assert property (p_en_set_hi)
        else $error("upper enable set port changed the wrong bits");

    property p_no_stray_set;
        !engine_take && !early_take |=>
            ((st_q.completion_pending & ~$past(st_q.completion_pending)) == '0);
    endproperty
    a_no_stray_set: assert property (p_no_stray_set)
        else $error("pending bit rose without a qualified completion");

    property p_early_sets;
        early_take |=> st_q.completion_pending[$past(ctrl_early_done.completion_code)];
    endproperty
    a_early_sets: assert property (p_early_sets)
        else $error("early completion code was not recorded");

    property p_engine_sets;
        engine_take |=> st_q.completion_pending[$past(engine_done.completion_code)];
    endproperty
    a_engine_sets: assert property (p_engine_sets)
        else $error("engine completion code was not recorded at its index");

    property p_upper_half;
        engine_take && engine_done.completion_code[5] && !early_take |=>
            ((st_q.completion_pending[31:0] & ~$past(st_q.completion_pending[31:0])) == '0) &&
            st_q.completion_pending[32 + $past(engine_done.completion_code[4:0])];
    endproperty
    a_upper_half: assert property (p_upper_half)
        else $error("code above 31 did not land in the upper half");

    property p_sticky;
        !wr_pend_clr_lo && !wr_pend_clr_hi |=>
            (($past(st_q.completion_pending) & ~st_q.completion_pending) == '0);
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("pending bit dropped without a clear write");

    property p_pend_clr_lo;
        wr_pend_clr_lo && !engine_take && !early_take |=>
            ((st_q.completion_pending[31:0] & $past(apb_req.pwdata)) == '0)
            && (st_q.completion_pending[63:32] == $past(st_q.completion_pending[63:32]));
    endproperty
    a_pend_clr_lo: assert property (p_pend_clr_lo)
        else $error("low pending clear port missed or overreached");

    property p_pend_clr_hi;
        wr_pend_clr_hi && !engine_take && !early_take |=>
            ((st_q.completion_pending[63:32] & $past(apb_req.pwdata)) == '0);
    endproperty
    a_pend_clr_hi: assert property (p_pend_clr_hi)
        else $error("upper pending clear port did not clear");

    property p_rearm;
        $rose(st_q.irq) |-> $past(st_q.armed);
    endproperty
    a_rearm: assert property (p_rearm)
        else $error("interrupt rose again before all pending bits cleared");

    property p_read_pend;
        rd_pend_lo |=> pready && (prdata == $past(st_q.completion_pending[31:0]));
    endproperty
    a_read_pend: assert property (p_read_pend)
        else $error("pending read returned the wrong value or late");

    property p_onehot;
        engine_take && !early_take && !wr_pend_clr_lo && !wr_pend_clr_hi |=>
            $countones(st_q.completion_pending & ~$past(st_q.completion_pending)) <= 1;
    endproperty
    a_onehot: assert property (p_onehot)
        else $error("one code set more than one pending bit");

    property p_gate;
        (live_vec == '0) |=> !done_irq;
    endproperty
    a_gate: assert property (p_gate)
        else $error("interrupt high with no enabled pending bit");

    property p_en_clr;
        wr_en_clr_lo && !wr_en_set_lo |=>
            ((st_q.irq_enable_mask[31:0] & $past(apb_req.pwdata)) == '0);
    endproperty
    a_en_clr: assert property (p_en_clr)
        else $error("enable clear port left a written bit set");

    property p_irq_cause;
        done_irq |-> (st_q.completion_pending & st_q.irq_enable_mask) != '0;
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt high without an enabled pending bit");

    property p_en_clr_hi;
        wr_en_clr_hi |=> ((st_q.irq_enable_mask[63:32] & $past(apb_req.pwdata)) == '0)
            && (st_q.irq_enable_mask[31:0] == $past(st_q.irq_enable_mask[31:0]));
    endproperty
    a_en_clr_hi: assert property (p_en_clr_hi)
        else $error("upper enable clear port missed or overreached");

    // with no enable port written the mask must not move
    property p_mask_hold;
        !wr_en_set_lo && !wr_en_set_hi && !wr_en_clr_lo && !wr_en_clr_hi |=>
            (st_q.irq_enable_mask == $past(st_q.irq_enable_mask));
    endproperty
    a_mask_hold: assert property (p_mask_hold)
        else $error("enable mask changed without an enable port write");

    property p_both_sources;
        engine_take && early_take |=>
            st_q.completion_pending[$past(engine_done.completion_code)] &&
            st_q.completion_pending[$past(ctrl_early_done.completion_code)];
    endproperty
    a_both_sources: assert property (p_both_sources)
        else $error("one of two same-cycle completions was lost");

    property p_set_wins;
        ((set_vec & pend_clr_vec) != '0) |=>
            ((st_q.completion_pending & $past(set_vec)) == $past(set_vec));
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("clear write beat a completion in the same cycle");

    property p_pend_ro;
        wr_pend_ro && !engine_take && !early_take |=>
            (st_q.completion_pending == $past(st_q.completion_pending));
    endproperty
    a_pend_ro: assert property (p_pend_ro)
        else $error("write to a pending word changed it");

    property p_read_pend_hi;
        rd_pend_hi |=> pready && (prdata == $past(st_q.completion_pending[63:32]));
    endproperty
    a_read_pend_hi: assert property (p_read_pend_hi)
        else $error("upper pending read returned the wrong value or late");

    // once fired and not re-armed, the line may not rise again
    property p_no_rearm;
        !st_q.armed && !done_irq |=> !done_irq;
    endproperty
    a_no_rearm: assert property (p_no_rearm)
        else $error("interrupt rose while pending bits were still set");

    property p_irq_level;
        done_irq && (live_vec != '0) |=> done_irq;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt dropped while an enabled bit still pends");

    // main scenarios
    c_irq_rise: cover property ($rose(done_irq));
    c_both_sources: cover property (engine_take && early_take);
    c_set_beats_clear: cover property (engine_take && wr_pend_clr_lo);
    c_unmapped: cover property (pready && pslverr);
    c_gated_off: cover property ($fell(done_irq) && (st_q.completion_pending != '0));

endmodule // ddp_dma_done_irq_pending

`default_nettype wire

// ---- testbench/ddp_engine_model.sv ----
// transfer-engine stand-in: turns a finished channel into one completion report
// assumes the bench names the finished channel's options for one ref_clk cycle
`timescale 1ns/1ps
`default_nettype none

module ddp_engine_model
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // finished transfer, as the bench describes it
    input wire logic fin_req,
    input wire logic fin_final,
    input wire logic [5:0] fin_code,
    input wire logic [1:0] fin_irq_en,
    // report towards the pending logic
    output var ddp_pkg::ddp_done_s engine_done
);
    import ddp_pkg::*;

    // one registered pulse per finish; between reports the code lines wander
    // so that a design sampling outside valid sees the inverted code and the old code in turn
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            engine_done <= '0;
        end
        else
        begin
            engine_done.valid <= fin_req;
            engine_done.final_hit <= fin_req ? fin_final : ~engine_done.final_hit;
            engine_done.final_done_irq_en <= fin_irq_en[1];
            engine_done.interim_done_irq_en <= fin_irq_en[0];
            engine_done.completion_code <= fin_req ? fin_code
                : ~engine_done.completion_code;
        end
    end

endmodule // ddp_engine_model

`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking bench for the completion-pending interrupt block
// assumes the engine stand-in model and a 20 mhz ref_clk
`timescale 1ns/1ps
`default_nettype none

module tb;
    import ddp_pkg::*;

    typedef struct packed {
        logic early;
        logic fin;
        logic [1:0] en;
        logic [5:0] code;
        logic [63:0] pend;
    } ddp_row_s;

    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    ddp_apb_req_s apb_req = '0;
    ddp_done_s ctrl_early_done = '0;
    ddp_done_s engine_done;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic done_irq;
    logic fin_req = 1'b0;
    logic fin_final = 1'b0;
    logic [5:0] fin_code = 6'h00;
    logic [1:0] fin_irq_en = 2'h0;
    logic [31:0] rdat;
    logic rerr;
    int num_errors = 0;
    int total_checks = 0;
    // source, kind, enables (final, interim), code, expected pending
    ddp_row_s rows [7] = '{
        '{1'b0, 1'b1, 2'h2, 6'h00, 64'h0000000000000001},
        '{1'b0, 1'b0, 2'h1, 6'h1f, 64'h0000000080000000},
        '{1'b1, 1'b1, 2'h3, 6'h20, 64'h0000000100000000},
        '{1'b1, 1'b0, 2'h1, 6'h3f, 64'h8000000000000000},
        '{1'b0, 1'b1, 2'h1, 6'h05, 64'h0000000000000000},
        '{1'b1, 1'b0, 2'h2, 6'h28, 64'h0000000000000000},
        '{1'b0, 1'b0, 2'h3, 6'h11, 64'h0000000000020000}};

    always #25 ref_clk = ~ref_clk;

    ddp_dma_done_irq_pending ddp_dma_done_irq_pending_inst (.ref_clk(ref_clk), .rst(rst),
        .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .engine_done(engine_done), .ctrl_early_done(ctrl_early_done), .done_irq(done_irq));

    ddp_engine_model ddp_engine_model_inst (.ref_clk(ref_clk), .rst(rst), .fin_req(fin_req),
        .fin_final(fin_final), .fin_code(fin_code), .fin_irq_en(fin_irq_en),
        .engine_done(engine_done));

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    // one apb transfer; the edge before setup keeps drivers from double assignment
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        apb_req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge ref_clk);
        apb_req.penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        rdat = prdata;
        rerr = pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            num_errors++;
            $display("[ERR] %0t bus answer timed out", $time);
            report_and_stop();
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rdat, exp);
    endtask

    // early reports come straight from the bench, normal ones via the engine
    task automatic done(input logic early, input logic fin, input logic [1:0] en,
        input logic [5:0] code);
        @(posedge ref_clk);
        if (early)
            ctrl_early_done <= '{1'b1, fin, en[1], en[0], code};
        else
        begin
            fin_req <= 1'b1;
            fin_final <= fin;
            fin_irq_en <= en;
            fin_code <= code;
        end
        @(posedge ref_clk);
        ctrl_early_done <= '{1'b0, ~fin, ~en[1], ~en[0], ~code};
        fin_req <= 1'b0;
    endtask

    task automatic wait_irq(input logic exp);
        int n;
        n = 0;
        while (done_irq !== exp && n < 8)
        begin
            @(posedge ref_clk);
            n++;
        end
        chk_bit(done_irq, exp);
    endtask

    initial
    begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        rd_chk(DDP_OFF_PEND_LO, 32'h00000000);
        rd_chk(DDP_OFF_PEND_HI, 32'h00000000);
        chk_bit(done_irq, 1'b0);
        // each row: one report, both halves read back, then everything wiped
        foreach (rows[i])
        begin
            done(rows[i].early, rows[i].fin, rows[i].en, rows[i].code);
            rd_chk(DDP_OFF_PEND_LO, rows[i].pend[31:0]);
            rd_chk(DDP_OFF_PEND_HI, rows[i].pend[63:32]);
            apb(1'b1, DDP_OFF_PEND_CLR_LO, 32'hffffffff);
            apb(1'b1, DDP_OFF_PEND_CLR_HI, 32'hffffffff);
        end
        // both sources report in one cycle: each code gets its own bit
        @(posedge ref_clk);
        fin_req <= 1'b1;
        fin_final <= 1'b1;
        fin_irq_en <= 2'h2;
        fin_code <= 6'h03;
        @(posedge ref_clk);
        fin_req <= 1'b0;
        ctrl_early_done <= '{1'b1, 1'b1, 1'b1, 1'b0, 6'h24};
        @(posedge ref_clk);
        ctrl_early_done <= '{1'b0, 1'b0, 1'b0, 1'b0, 6'h00};
        rd_chk(DDP_OFF_PEND_LO, 32'h00000008);
        rd_chk(DDP_OFF_PEND_HI, 32'h00000010);
        apb(1'b1, DDP_OFF_PEND_CLR_LO, 32'h00000008);
        apb(1'b1, DDP_OFF_PEND_CLR_HI, 32'h00000010);
        // a completion taken on the edge that lands a clear of its bit survives
        fork
            apb(1'b1, DDP_OFF_PEND_CLR_LO, 32'h00000200);
            begin
                repeat (2) @(posedge ref_clk);
                ctrl_early_done <= '{1'b1, 1'b1, 1'b1, 1'b0, 6'h09};
                @(posedge ref_clk);
                ctrl_early_done <= '{1'b0, 1'b0, 1'b0, 1'b0, 6'h00};
            end
        join
        rd_chk(DDP_OFF_PEND_LO, 32'h00000200);
        apb(1'b1, DDP_OFF_PEND_CLR_LO, 32'h00000200);
        // zero bits in set and clear words must leave the mask alone
        apb(1'b1, DDP_OFF_EN_SET_LO, 32'h00000021);
        apb(1'b1, DDP_OFF_EN_SET_LO, 32'h00000000);
        rd_chk(DDP_OFF_EN_MASK_LO, 32'h00000021);
        apb(1'b1, DDP_OFF_EN_SET_HI, 32'h80000001);
        apb(1'b1, DDP_OFF_EN_CLR_LO, 32'h00000001);
        apb(1'b1, DDP_OFF_EN_CLR_HI, 32'h00000000);
        rd_chk(DDP_OFF_EN_MASK_LO, 32'h00000020);
        rd_chk(DDP_OFF_EN_MASK_HI, 32'h80000001);
        // enabled code 5 and masked code 6; a write to the pending word is ignored
        done(1'b0, 1'b1, 2'h2, 6'h05);
        done(1'b1, 1'b1, 2'h2, 6'h06);
        wait_irq(1'b1);
        apb(1'b1, DDP_OFF_PEND_LO, 32'h00000000);
        repeat (20) @(posedge ref_clk);
        rd_chk(DDP_OFF_PEND_LO, 32'h00000060);
        apb(1'b1, DDP_OFF_PEND_CLR_LO, 32'h00000020);
        rd_chk(DDP_OFF_PEND_LO, 32'h00000040);
        wait_irq(1'b0);
        // code 6 still pends, so a fresh enabled code may not fire again
        done(1'b0, 1'b1, 2'h2, 6'h20);
        repeat (4) @(posedge ref_clk);
        chk_bit(done_irq, 1'b0);
        apb(1'b1, DDP_OFF_PEND_CLR_HI, 32'h00000001);
        apb(1'b1, DDP_OFF_PEND_CLR_LO, 32'h00000040);
        rd_chk(DDP_OFF_PEND_HI, 32'h00000000);
        done(1'b1, 1'b0, 2'h1, 6'h3f);
        wait_irq(1'b1);
        apb(1'b1, DDP_OFF_EN_CLR_HI, 32'h80000000);
        wait_irq(1'b0);
        rd_chk(DDP_OFF_PEND_HI, 32'h80000000);
        // unmapped address answers with an error and reads zero
        apb(1'b0, 8'h28, 32'h00000000);
        chk_bit(rerr, 1'b1);
        chk(rdat, 32'h00000000);
        // reset in mid-run wipes what is pending
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rd_chk(DDP_OFF_PEND_HI, 32'h00000000);
        rd_chk(DDP_OFF_EN_MASK_LO, 32'h00000000);
        chk_bit(done_irq, 1'b0);
        report_and_stop();
    end

endmodule // tb

`default_nettype wire
